// file: dv/blinit_boot_loader_asserts.sv
// Purpose: port checks of the boot loader and init line
// Assumes: one clock domain, reset_i synchronous active high
// Notes:   controller reset is only pulled while the flash is idle
`timescale 1ns/1ps
module blinit_boot_loader_asserts
(
  input wire logic                     ref_clk_i,
  input wire logic                     reset_i,
  input wire logic                     controller_reset_n_i,
  input wire logic                     autoinit_done_i,
  input wire logic                     aux_select_i,
  input wire logic                     prog_ready_i,
  input wire blinit_pkg::blinit_spi_t  flash_o,
  input wire blinit_pkg::blinit_prog_t prog_o,
  input wire logic                     init_busy_o,
  input wire logic                     init_busy_oe_o,
  input wire logic                     autoinit_run_o,
  input wire logic                     host_accept_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  ctl_reset_a: assert property (!controller_reset_n_i [*4] |-> !init_busy_oe_o)
    else $error("init line driven in controller reset");
  boot_undriven_a: assert property (!autoinit_run_o && !host_accept_o |-> !init_busy_oe_o)
    else $error("init line driven during boot");
  run_high_a: assert property (autoinit_run_o |-> init_busy_oe_o && init_busy_o)
    else $error("init line not driven high in auto-init");
  done_low_a: assert property (autoinit_run_o && autoinit_done_i |=> ##1
    (!init_busy_o && init_busy_oe_o && host_accept_o && !autoinit_run_o))
    else $error("init line not low after done");
  accept_after_a: assert property (host_accept_o |-> init_busy_oe_o && !init_busy_o)
    else $error("host accepted before init done");
  stay_low_a: assert property (!init_busy_o && init_busy_oe_o && controller_reset_n_i
    |=> !init_busy_o)
    else $error("init line left low level");
  sel_one_idle_a: assert property (!host_accept_o && !$past(host_accept_o) |-> flash_o.sel1_n)
    else $error("select one active before init done");
  aux_select_a: assert property (host_accept_o && aux_select_i |-> ##[1:2] !flash_o.sel1_n)
    else $error("select one does not follow request");
  sclk_idle_a: assert property (flash_o.sel0_n && flash_o.sel1_n |-> !flash_o.sclk)
    else $error("serial clock not idle low");
  mosi_on_fall_a: assert property (!flash_o.sel0_n && flash_o.sclk |-> $stable(flash_o.mosi))
    else $error("data out changed with clock high");
  sel_gap_a: assert property ($rose(flash_o.sel0_n) |-> !$past(flash_o.sclk)
    ##1 flash_o.sel0_n [*8])
    else $error("select zero dropped mid byte or gap short");
  prog_hold_a: assert property (prog_o.valid && !prog_ready_i |=> prog_o.valid
    && $stable(prog_o.addr) && $stable(prog_o.data))
    else $error("program beat changed while stalled");

  cover property ($rose(autoinit_run_o));
  cover property ($fell(init_busy_o));
  cover property (prog_o.valid && !prog_ready_i);
  cover property (!flash_o.sel1_n);
endmodule

// file: dv/blinit_boot_loader_bench.sv
// Purpose: self-checking bench of the boot loader and init line
// Assumes: flash model on select zero, pull-up on the init line
// Notes:   short byte count and late limit keep the run brief
`timescale 1ns/1ps
module blinit_boot_loader_bench;
  localparam int NBYTES = 48;
  localparam int LATE_CYC = 8000;

  logic                     ref_clk_i = 1'b0;
  logic                     reset_i = 1'b1;
  logic                     controller_reset_n_i = 1'b0;
  logic                     flash_miso_i;
  logic                     autoinit_done_i = 1'b0;
  logic                     aux_select_i = 1'b0;
  logic                     prog_ready_i = 1'b0;
  logic                     stall = 1'b1;
  blinit_pkg::blinit_spi_t  flash_o;
  blinit_pkg::blinit_prog_t prog_o;
  logic                     init_busy_o;
  logic                     init_busy_oe_o;
  logic                     autoinit_run_o;
  logic                     host_accept_o;
  logic                     init_late_o;
  wire                      init_line = init_busy_oe_o ? init_busy_o : 1'b1;
  int                       n_mismatch = 0;
  int                       checks_done = 0;
  int                       cyc = 0;
  int                       beats = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;

  blinit_boot_loader #(.PROG_BYTES(NBYTES), .INIT_TYPICAL_CYC(LATE_CYC)) uut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .controller_reset_n_i(controller_reset_n_i),
    .flash_miso_i(flash_miso_i), .autoinit_done_i(autoinit_done_i),
    .aux_select_i(aux_select_i), .prog_ready_i(prog_ready_i), .flash_o(flash_o),
    .prog_o(prog_o), .init_busy_o(init_busy_o), .init_busy_oe_o(init_busy_oe_o),
    .autoinit_run_o(autoinit_run_o), .host_accept_o(host_accept_o),
    .init_late_o(init_late_o));

  blinit_flash_model flash (.sclk_i(flash_o.sclk), .mosi_i(flash_o.mosi),
    .sel_n_i(flash_o.sel0_n), .miso_o(flash_miso_i));

  // Irregular acceptance so beats meet both back-to-back and gaps
  always @(negedge ref_clk_i)
  begin
    cyc++;
    prog_ready_i <= !stall && (cyc % 3 != 0);
  end

  always @(posedge ref_clk_i)
    if (prog_o.valid && prog_ready_i)
    begin
      chk(prog_o.addr, beats);
      chk(prog_o.data, beats[7:0] ^ 8'ha5);
      beats++;
    end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pulse_done();
    autoinit_done_i = 1'b1;
    @(negedge ref_clk_i);
    autoinit_done_i = 1'b0;
    @(negedge ref_clk_i);
  endtask

  task automatic t_reset();
    repeat (10) @(negedge ref_clk_i);
    chk(init_busy_oe_o, 0);
    chk(init_line, 1);
    chk(flash_o, 4'h3);
    reset_i = 1'b0;
    controller_reset_n_i = 1'b1;
  endtask

  task automatic t_boot();
    logic [23:0] held;
    logic [7:0]  exp_cmd[9] = '{8'h06, 8'h05, 8'h05, 8'h05, 8'h01, 8'h05, 8'h05, 8'h05, 8'h0b};
    repeat (20) @(negedge ref_clk_i);
    pulse_done();
    for (int k = 0; k < 8000 && prog_o.valid !== 1'b1; k++)
      @(negedge ref_clk_i);
    repeat (800) @(negedge ref_clk_i);
    held = flash.addr;
    chk(init_busy_oe_o, 0);
    repeat (200) @(negedge ref_clk_i);
    chk(flash.addr, held);
    chk(int'(flash.first_hi), blinit_pkg::SLOW_HALF_CYC * 25);
    chk(int'(flash.last_hi), blinit_pkg::FAST_HALF_CYC * 25);
    stall = 1'b0;
    for (int k = 0; k < 4000 && autoinit_run_o !== 1'b1; k++)
      @(negedge ref_clk_i);
    chk(beats, NBYTES);
    chk(flash.rd_addr, 0);
    chk(flash.cmd_q.size(), 9);
    foreach (exp_cmd[i])
      chk(flash.cmd_q[i], exp_cmd[i]);
    chk({init_busy_oe_o, init_line}, 2'h3);
    chk(host_accept_o, 0);
  endtask

  task automatic t_done();
    chk(init_late_o, 0);
    pulse_done();
    chk(init_line, 0);
    chk(host_accept_o, 1);
    aux_select_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    chk({flash_o.sel0_n, flash_o.sel1_n}, 2'h2);
    aux_select_i = 1'b0;
    repeat (100) @(negedge ref_clk_i);
    chk(init_line, 0);
  endtask

  task automatic t_restart();
    controller_reset_n_i = 1'b0;
    repeat (5) @(negedge ref_clk_i);
    chk({init_busy_oe_o, host_accept_o, init_line}, 3'h1);
    flash.cmd_q.delete();
    beats = 0;
    controller_reset_n_i = 1'b1;
    for (int k = 0; k < 8000 && autoinit_run_o !== 1'b1; k++)
      @(negedge ref_clk_i);
    chk(flash.cmd_q[0], 8'h06);
    chk(beats, NBYTES);
    chk(init_late_o, 0);
    for (int k = 0; k < LATE_CYC && init_late_o !== 1'b1; k++)
      @(negedge ref_clk_i);
    chk({init_late_o, init_line}, 2'h3);
    pulse_done();
    chk(init_line, 0);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    t_reset();
    t_boot();
    t_done();
    t_restart();
    test_done();
  end

  // About three times the expected run
  initial
  begin
    repeat (40000) @(posedge ref_clk_i);
    n_mismatch++;
    test_done();
  end
endmodule

bind blinit_boot_loader blinit_boot_loader_asserts chk_i (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .controller_reset_n_i(controller_reset_n_i),
  .autoinit_done_i(autoinit_done_i), .aux_select_i(aux_select_i),
  .prog_ready_i(prog_ready_i), .flash_o(flash_o), .prog_o(prog_o),
  .init_busy_o(init_busy_o), .init_busy_oe_o(init_busy_oe_o),
  .autoinit_run_o(autoinit_run_o), .host_accept_o(host_accept_o));

// file: dv/blinit_flash_model.sv
// Purpose: serial flash on select zero, far side of the boot loader
// Assumes: mode 0, one lane each way, one status byte per status read
// Notes:   latch bit sets late and busy bit clears late so that polls must repeat
`timescale 1ns/1ps
module blinit_flash_model #(
  parameter int WEL_POLLS = 2,
  parameter int WIP_POLLS = 2
)
(
  input  wire logic sclk_i,
  input  wire logic mosi_i,
  input  wire logic sel_n_i,
  output logic      miso_o
);
  logic [7:0]  cmd;
  logic [7:0]  sh;
  logic [7:0]  tx;
  logic [7:0]  cmd_q[$];
  logic [23:0] addr;
  logic [23:0] rd_addr;
  logic        write_enable_latch_bit = 1'b0;
  int          bits = 0;
  int          wel_wait = 0;
  int          wip_cnt = 0;
  realtime     t_hi = 0;
  realtime     first_hi = 0;
  realtime     last_hi = 0;

  initial
    miso_o = 1'b0;

  always @(negedge sel_n_i)
    bits = 0;

  // Released line shows the opposite level so a stale bit never reads as good
  always @(posedge sel_n_i)
    miso_o = ~miso_o;

  always @(posedge sclk_i)
  begin
    t_hi = $realtime;
    if (!sel_n_i)
    begin
      sh = {sh[6:0], mosi_i};
      bits++;
      if (bits % 8 == 0)
        take_byte(bits / 8);
    end
  end

  // Pulses count only while selected; the clock leaving unknown at start is none
  always @(negedge sclk_i)
  begin
    if (!sel_n_i)
    begin
      last_hi = $realtime - t_hi;
      if (first_hi == 0)
        first_hi = last_hi;
      miso_o = tx[7];
      tx = tx << 1;
    end
  end

  task automatic take_byte(input int n);
    if (n == 1)
    begin
      cmd = sh;
      cmd_q.push_back(sh);
    end
    if (n == 1 && sh == 8'h06)
    begin
      write_enable_latch_bit = 1'b1;
      wel_wait = WEL_POLLS;
    end
    if (n == 1 && sh == 8'h05)
    begin
      tx = {6'h00, write_enable_latch_bit && wel_wait == 0, wip_cnt != 0};
      wel_wait = (wel_wait > 0) ? wel_wait - 1 : 0;
      wip_cnt = (wip_cnt > 0) ? wip_cnt - 1 : 0;
    end
    if (n == 2 && cmd == 8'h01)
    begin
      write_enable_latch_bit = 1'b0;
      wip_cnt = WIP_POLLS;
    end
    if (cmd == 8'h0b && n > 1 && n < 5)
      addr = {addr[15:0], sh};
    if (cmd == 8'h0b && n == 4)
      rd_addr = addr;
    if (cmd == 8'h0b && n > 4)
    begin
      tx = addr[7:0] ^ 8'ha5;
      addr = addr + 24'h000001;
    end
  endtask
endmodule

// file: logic/blinit_boot_loader.sv
// Purpose: boot from serial flash, copy code to program memory, run auto-init flag
// Assumes: flash on select zero, SPI mode 0, program memory write port on ref_clk_i
// Notes:   controller_reset_n_i low holds the whole block idle, like reset_i
`timescale 1ns/1ps
module blinit_boot_loader #(
  parameter int unsigned  PROG_BYTES       = blinit_pkg::PROG_BYTES_DEF,
  parameter logic [23:0]  BOOT_BASE        = 24'h000000,
  parameter int unsigned  INIT_TYPICAL_CYC = blinit_pkg::INIT_TYPICAL_CYC,
  parameter int unsigned  FIFO_DEPTH       = blinit_pkg::FIFO_DEPTH
)
(
  input  wire logic                     ref_clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     controller_reset_n_i,
  input  wire logic                     flash_miso_i,
  input  wire logic                     autoinit_done_i,
  input  wire logic                     aux_select_i,
  input  wire logic                     prog_ready_i,
  output blinit_pkg::blinit_spi_t       flash_o,
  output blinit_pkg::blinit_prog_t      prog_o,
  output logic                          init_busy_o,
  output logic                          init_busy_oe_o,
  output logic                          autoinit_run_o,
  output logic                          host_accept_o,
  output logic                          init_late_o
);
  localparam logic [24:0] READ_LAST = blinit_pkg::READ_HDR_BYTES + 25'(PROG_BYTES) - 25'h1;
  localparam logic [3:0]  SLOW_LAST = 4'(blinit_pkg::SLOW_HALF_CYC - 1);
  localparam logic [3:0]  FAST_LAST = 4'(blinit_pkg::FAST_HALF_CYC - 1);
  localparam logic [7:0]  GAP_CYC   = 8'(blinit_pkg::DESELECT_CYC);
  localparam logic [26:0] LATE_CYC  = 27'(INIT_TYPICAL_CYC);

  blinit_pkg::blinit_state_t state;
  blinit_pkg::blinit_state_t next_after;

  logic        miso_meta;
  logic        miso_sync;
  logic        crst_meta;
  logic        crst_sync;
  logic        hold;

  logic        txn_active;
  logic [7:0]  gap_cnt;
  logic [24:0] idx;
  logic [24:0] last_idx;
  logic        fast;

  logic        eng_busy;
  logic        byte_done;
  logic [2:0]  bit_cnt;
  logic [3:0]  half_cnt;
  logic [7:0]  tx_shift;
  logic [7:0]  rx_shift;
  logic [7:0]  next_tx;
  logic        start;
  logic        capture;

  logic        sclk;
  logic        mosi;
  logic        sel0_n;
  logic        sel1_n;

  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [7:0]  fifo_out_data;

  logic        prog_valid;
  logic [23:0] prog_addr;
  logic [7:0]  prog_data;
  logic [26:0] late_cnt;

  // Both the flash data pin and the controller reset pin are asynchronous
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      miso_meta <= 1'b0;
      miso_sync <= 1'b0;
      crst_meta <= 1'b0;
      crst_sync <= 1'b0;
    end
    else
    begin
      miso_meta <= flash_miso_i;
      miso_sync <= miso_meta;
      crst_meta <= controller_reset_n_i;
      crst_sync <= crst_meta;
    end
  end

  assign hold = reset_i || !crst_sync;

  // Byte count of each flash transaction, last index inclusive
  always_comb
  begin
    case (state)
      blinit_pkg::BLINIT_POLL_WEL: last_idx = 25'h1;
      blinit_pkg::BLINIT_WRSR:     last_idx = 25'h1;
      blinit_pkg::BLINIT_POLL_WIP: last_idx = 25'h1;
      blinit_pkg::BLINIT_READ:     last_idx = READ_LAST;
      default:                     last_idx = 25'h0;
    endcase
  end

  // Byte to shift for the current state and position
  always_comb
  begin
    next_tx = blinit_pkg::DUMMY_BYTE;
    case (state)
      blinit_pkg::BLINIT_WRITE_ENABLE_COMMAND:
      begin
        next_tx = blinit_pkg::CMD_WRITE_ENABLE;
      end
      blinit_pkg::BLINIT_POLL_WEL, blinit_pkg::BLINIT_POLL_WIP:
      begin
        next_tx = (idx == 25'h0) ? blinit_pkg::CMD_READ_STATUS : blinit_pkg::DUMMY_BYTE;
      end
      blinit_pkg::BLINIT_WRSR:
      begin
        next_tx = (idx == 25'h0) ? blinit_pkg::CMD_WRITE_STATUS : blinit_pkg::STATUS_UNPROTECT;
      end
      blinit_pkg::BLINIT_READ:
      begin
        // Full 24-bit address reaches every byte of a 16 MB part
        case (idx)
          25'h0:   next_tx = blinit_pkg::CMD_FAST_READ;
          25'h1:   next_tx = BOOT_BASE[23:16];
          25'h2:   next_tx = BOOT_BASE[15:8];
          25'h3:   next_tx = BOOT_BASE[7:0];
          default: next_tx = blinit_pkg::DUMMY_BYTE;
        endcase
      end
      default:
      begin
        next_tx = blinit_pkg::DUMMY_BYTE;
      end
    endcase
  end

  // Successor once a transaction's last byte is in
  always_comb
  begin
    case (state)
      blinit_pkg::BLINIT_WRITE_ENABLE_COMMAND:
      begin
        next_after = blinit_pkg::BLINIT_POLL_WEL;
      end
      blinit_pkg::BLINIT_POLL_WEL:
      begin
        next_after = rx_shift[blinit_pkg::STATUS_WEL_BIT] ?
                     blinit_pkg::BLINIT_WRSR : blinit_pkg::BLINIT_POLL_WEL;
      end
      blinit_pkg::BLINIT_WRSR:
      begin
        next_after = blinit_pkg::BLINIT_POLL_WIP;
      end
      blinit_pkg::BLINIT_POLL_WIP:
      begin
        next_after = rx_shift[blinit_pkg::STATUS_BUSY_BIT] ?
                     blinit_pkg::BLINIT_POLL_WIP : blinit_pkg::BLINIT_READ;
      end
      blinit_pkg::BLINIT_READ:
      begin
        next_after = blinit_pkg::BLINIT_DRAIN;
      end
      default:
      begin
        next_after = blinit_pkg::BLINIT_HOLD;
      end
    endcase
  end

  // A data byte is only started while the FIFO has room, so a stalled
  // program memory stops the serial clock instead of losing bytes
  assign start = txn_active && !eng_busy && !byte_done && !capture &&
                 ((state != blinit_pkg::BLINIT_READ) ||
                  (idx < blinit_pkg::READ_HDR_BYTES) || fifo_in_ready);

  // Byte engine: mode 0, clock idles low
  always_ff @(posedge ref_clk_i)
  begin
    if (hold)
    begin
      eng_busy  <= 1'b0;
      byte_done <= 1'b0;
      bit_cnt   <= 3'h0;
      half_cnt  <= 4'h0;
      tx_shift  <= 8'h00;
      rx_shift  <= 8'h00;
      capture   <= 1'b0;
      sclk      <= 1'b0;
      mosi      <= 1'b0;
    end
    else
    begin
      byte_done <= 1'b0;
      capture   <= 1'b0;
      if (capture)
      begin
        // The pin lags two cycles, more than a fast half period, so the bit
        // launched at the previous fall is taken one cycle after this fall
        rx_shift  <= {rx_shift[6:0], miso_sync};
        byte_done <= !eng_busy;
      end
      if (start)
      begin
        eng_busy <= 1'b1;
        tx_shift <= next_tx;
        mosi     <= next_tx[7];
        bit_cnt  <= 3'h0;
        half_cnt <= 4'h0;
      end
      else if (eng_busy)
      begin
        if (half_cnt == (fast ? FAST_LAST : SLOW_LAST))
        begin
          half_cnt <= 4'h0;
          if (!sclk)
          begin
            sclk <= 1'b1;
          end
          else
          begin
            // Sampling on the falling edge tolerates slow flash clock-to-out
            sclk     <= 1'b0;
            capture  <= 1'b1;
            bit_cnt  <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
            begin
              eng_busy  <= 1'b0;
            end
            else
            begin
              mosi     <= tx_shift[6];
              tx_shift <= {tx_shift[6:0], 1'b0};
            end
          end
        end
        else
        begin
          half_cnt <= half_cnt + 4'h1;
        end
      end
    end
  end

  // Boot sequencer
  always_ff @(posedge ref_clk_i)
  begin
    if (hold)
    begin
      state      <= blinit_pkg::BLINIT_HOLD;
      txn_active <= 1'b0;
      sel0_n     <= 1'b1;
      gap_cnt    <= 8'h00;
      idx        <= 25'h0;
      fast       <= 1'b0;
    end
    else
    begin
      case (state)
        blinit_pkg::BLINIT_HOLD:
        begin
          // First cycle with the controller reset released
          state <= blinit_pkg::BLINIT_WRITE_ENABLE_COMMAND;
        end
        blinit_pkg::BLINIT_WRITE_ENABLE_COMMAND, blinit_pkg::BLINIT_POLL_WEL, blinit_pkg::BLINIT_WRSR,
        blinit_pkg::BLINIT_POLL_WIP, blinit_pkg::BLINIT_READ:
        begin
          if (gap_cnt != 8'h00)
          begin
            gap_cnt <= gap_cnt - 8'h01;
          end
          else if (!txn_active)
          begin
            txn_active <= 1'b1;
            sel0_n     <= 1'b0;
            idx        <= 25'h0;
          end
          else if (byte_done)
          begin
            if (idx == last_idx)
            begin
              txn_active <= 1'b0;
              sel0_n     <= 1'b1;
              gap_cnt    <= GAP_CYC;
              state      <= next_after;
              if (next_after == blinit_pkg::BLINIT_READ)
              begin
                fast <= 1'b1;
              end
            end
            else
            begin
              idx <= idx + 25'h1;
            end
          end
        end
        blinit_pkg::BLINIT_DRAIN:
        begin
          // All code must sit in program memory before control moves on
          if (!fifo_out_valid && !prog_valid)
          begin
            state <= blinit_pkg::BLINIT_INIT;
          end
        end
        blinit_pkg::BLINIT_INIT:
        begin
          if (autoinit_done_i)
          begin
            state <= blinit_pkg::BLINIT_DONE;
          end
        end
        blinit_pkg::BLINIT_DONE:
        begin
          state <= blinit_pkg::BLINIT_DONE;
        end
        default:
        begin
          state <= blinit_pkg::BLINIT_HOLD;
        end
      endcase
    end
  end

  assign fifo_in_valid = byte_done && (state == blinit_pkg::BLINIT_READ) &&
                         (idx >= blinit_pkg::READ_HDR_BYTES);
  assign fifo_out_ready = !prog_valid || prog_ready_i;

  blinit_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (hold),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rx_shift),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // Program memory write stage, one byte per accepted beat
  always_ff @(posedge ref_clk_i)
  begin
    if (hold)
    begin
      prog_valid <= 1'b0;
      prog_addr  <= 24'h000000;
      prog_data  <= 8'h00;
    end
    else if (fifo_out_valid && fifo_out_ready)
    begin
      prog_valid <= 1'b1;
      prog_data  <= fifo_out_data;
      if (prog_valid)
      begin
        prog_addr <= prog_addr + 24'h000001;
      end
    end
    else if (prog_ready_i && prog_valid)
    begin
      prog_valid <= 1'b0;
      prog_addr  <= prog_addr + 24'h000001;
    end
  end

  // Init status line: undriven through reset and boot, then high, then low
  always_ff @(posedge ref_clk_i)
  begin
    if (hold)
    begin
      init_busy_oe_o <= 1'b0;
      init_busy_o    <= 1'b1;
    end
    else
    begin
      case (state)
        blinit_pkg::BLINIT_INIT:
        begin
          init_busy_oe_o <= 1'b1;
          init_busy_o    <= 1'b1;
        end
        blinit_pkg::BLINIT_DONE:
        begin
          init_busy_oe_o <= 1'b1;
          init_busy_o    <= 1'b0;
        end
        default:
        begin
          init_busy_oe_o <= 1'b0;
          init_busy_o    <= 1'b1;
        end
      endcase
    end
  end

  // Host-facing flags and the second select, which only runs after boot
  always_ff @(posedge ref_clk_i)
  begin
    if (hold)
    begin
      host_accept_o  <= 1'b0;
      autoinit_run_o <= 1'b0;
      sel1_n         <= 1'b1;
    end
    else
    begin
      host_accept_o  <= (state == blinit_pkg::BLINIT_DONE);
      autoinit_run_o <= (state == blinit_pkg::BLINIT_INIT);
      sel1_n         <= !((state == blinit_pkg::BLINIT_DONE) && aux_select_i);
    end
  end

  // Overrun of the typical init time is flagged, not enforced
  always_ff @(posedge ref_clk_i)
  begin
    if (hold)
    begin
      late_cnt    <= 27'h0;
      init_late_o <= 1'b0;
    end
    else if (state != blinit_pkg::BLINIT_DONE)
    begin
      if (late_cnt != LATE_CYC)
      begin
        late_cnt <= late_cnt + 27'h1;
      end
      else
      begin
        init_late_o <= 1'b1;
      end
    end
  end

  // Single lane each way on one port
  assign flash_o = '{sclk: sclk, mosi: mosi, sel0_n: sel0_n, sel1_n: sel1_n};
  assign prog_o  = '{valid: prog_valid, addr: prog_addr, data: prog_data};
endmodule

// file: logic/blinit_fifo.sv
// Purpose: byte FIFO between the flash reader and program memory
// Assumes: single clock, synchronous active-high reset
// Notes:   full and empty derive from an exact fill count
`timescale 1ns/1ps
module blinit_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
)
(
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != FULL_CNT);
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge ref_clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// file: logic/blinit_pkg.sv
// Purpose: shared constants and carriers of the boot loader and init flag block
// Assumes: 40 MHz ref_clk_i, serial flash in SPI mode 0 on select zero
package blinit_pkg;

  localparam int unsigned CLK_KHZ        = 40000;
  localparam int unsigned SLOW_SCLK_KHZ  = 1420;
  localparam int unsigned FAST_SCLK_KHZ  = 30000;
  // Half periods round up so the serial clock never exceeds its nominal rate
  localparam int unsigned SLOW_HALF_CYC  = (CLK_KHZ + 2 * SLOW_SCLK_KHZ - 1) / (2 * SLOW_SCLK_KHZ);
  localparam int unsigned FAST_HALF_CYC  = (CLK_KHZ + 2 * FAST_SCLK_KHZ - 1) / (2 * FAST_SCLK_KHZ);
  localparam int unsigned DESELECT_CYC   = 2 * SLOW_HALF_CYC;
  localparam int unsigned INIT_TYPICAL_MS  = 1760;
  localparam int unsigned INIT_TYPICAL_CYC = INIT_TYPICAL_MS * CLK_KHZ;

  localparam int unsigned FLASH_ADDR_W   = 24;
  localparam int unsigned FIFO_DEPTH     = 32;
  localparam int unsigned PROG_BYTES_DEF = 4096;

  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h05;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] CMD_FAST_READ    = 8'h0b;
  localparam logic [7:0] STATUS_UNPROTECT = 8'h00;
  localparam logic [7:0] DUMMY_BYTE       = 8'h00;
  localparam int unsigned STATUS_BUSY_BIT = 0;
  localparam int unsigned STATUS_WEL_BIT  = 1;
  localparam logic [24:0] READ_HDR_BYTES  = 25'h0000005;

  typedef enum logic [8:0]
  {
    BLINIT_HOLD     = 9'h001,
    BLINIT_WRITE_ENABLE_COMMAND     = 9'h002,
    BLINIT_POLL_WEL = 9'h004,
    BLINIT_WRSR     = 9'h008,
    BLINIT_POLL_WIP = 9'h010,
    BLINIT_READ     = 9'h020,
    BLINIT_DRAIN    = 9'h040,
    BLINIT_INIT     = 9'h080,
    BLINIT_DONE     = 9'h100
  } blinit_state_t;

  typedef struct packed
  {
    logic sclk;
    logic mosi;
    logic sel0_n;
    logic sel1_n;
  } blinit_spi_t;

  typedef struct packed
  {
    logic                    valid;
    logic [FLASH_ADDR_W-1:0] addr;
    logic [7:0]              data;
  } blinit_prog_t;

endpackage
